// ===== rtl/wave_seq_pkg.sv
/*
  Constants and carrier types of the wave sequencer.
  Assumes one 40 MHz clock and no register bus.
*/
package wave_seq_pkg;

  // ----------------------------------------------------------------
  // Widths and table geometry.
  // ----------------------------------------------------------------
  localparam int POS_W       = 10;
  localparam int ENTRIES     = 256;
  localparam int TABLE_WORDS = 8;
  localparam int CUR_W       = 9;
  localparam int VEL_W       = 23;

  // ----------------------------------------------------------------
  // Reset values, caps and timing.
  // ----------------------------------------------------------------
  localparam logic [9:0]  POS_RESET    = 10'h000;
  localparam logic [8:0]  MAG_RESET    = 9'h000;
  localparam logic [8:0]  STEPS_RESET  = 9'h000;
  localparam logic [3:0]  OFF_TIME_CAP = 4'h8;
  localparam logic [3:0]  MAX_SHIFT    = 4'h8;
  localparam int CLK_PERIOD_NS     = 25;
  localparam int VEL_ADJ_PERIOD_NS = 1000;
  localparam int VEL_ADJ_CYCLES    = VEL_ADJ_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carrier types.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] x3;
    logic [7:0] x2;
    logic [7:0] x1;
    logic [1:0] w3;
    logic [1:0] w2;
    logic [1:0] w1;
    logic [1:0] w0;
  } seg_cfg_t;

  typedef struct packed {
    logic [7:0] unused_hi;
    logic [7:0] shifted;
    logic [7:0] unused_lo;
    logic [7:0] start;
  } start_cfg_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WALK = 1'b1
  } walk_state_t;

endpackage : wave_seq_pkg

// ===== rtl/wave_increment_table.sv
/*
  Quarter-wave increment store and slope lookup, two read ports.
  Assumes whole-word writes.
*/
module wave_increment_table #(
  parameter int WORD_W = 32,
  parameter int WORDS  = 8
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Table write port.
  input  wire logic                        wr_en,
  input  wire logic [$clog2(WORDS)-1:0]    wr_idx,
  input  wire logic [WORD_W-1:0]           wr_data,
  // Segment configuration.
  input  wave_seq_pkg::seg_cfg_t           seg,
  // Read ports, one per coil.
  input  wire logic [1:0][7:0]             rd_idx,
  output logic      [1:0][2:0]             rd_inc
);

  logic [WORD_W-1:0] mem [WORDS];

  // Words clear at reset; software loads the wave.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) mem[i] <= '0;
    end else if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // One lookup per coil: segment slope plus the entry bit.
  for (genvar c = 0; c < 2; c++) begin : g_port
    wire logic [7:0] ix    = rd_idx[c];
    wire logic       bit_v = mem[ix[7:5]][ix[4:0]];
    wire logic [1:0] code  = (ix < seg.x1) ? seg.w0 :
                             (ix < seg.x2) ? seg.w1 :
                             (ix < seg.x3) ? seg.w2 : seg.w3;
    // Code 0..3 is slope -1..2; the bit adds one.
    assign rd_inc[c] = 3'({1'b0, code}) - 3'h1 + 3'({2'b00, bit_v});
  end

endmodule : wave_increment_table

// ===== rtl/fullstep_velocity_ctrl.sv
/*
  Fullstep velocity governor: follows the target, backs off under
  overload, never below the floor while active. Assumes a one-cycle adjust tick.
*/
module fullstep_velocity_ctrl #(
  parameter int VEL_W = 23
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             active,
  input  wire logic             overload,
  input  wire logic [VEL_W-1:0] target,
  input  wire logic [VEL_W-1:0] floor_vel,
  output logic      [VEL_W-1:0] vel
);

  logic [VEL_W-1:0] next_vel;

  // Overload slows one unit per tick; relief climbs back to target.
  always_comb begin
    next_vel = vel;
    if (!active) begin
      next_vel = target;
    end else if (tick && overload) begin
      next_vel = (vel > floor_vel) ? vel - 1'b1 : floor_vel;
    end else if (tick) begin
      next_vel = (vel < target) ? vel + 1'b1 : target;
    end
    if (active && next_vel < floor_vel) begin
      next_vel = floor_vel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) vel <= '0;
    else        vel <= next_vel;
  end

endmodule : fullstep_velocity_ctrl

// ===== rtl/wave_sequencer.sv
/*
  Microstep wave sequencer with fullstep commutation.
  Expands a quarter wave into two coil currents and
  governs fullstep velocity, chopper hand-over and stall stop.
  Assumes inputs synchronous to I_CORE_CLK; software drives the
  configuration and the ramp side supplies velocity and steps.
*/
// Contract
// - Fullstep runs at target velocity, slower under overload.
// - Minimum velocity up to 2^22; zero disables fullstep.
// - Below the minimum the motor runs normal microsteps.
// - In fullstep mode velocity never falls below the minimum.
// - Both flags set and minimum exceeded select fullstep.
// - Above the minimum the quiet chopper is off; the code turns it off only in fullstep mode, with both flags set.
// - Stop-on-stall with a detected stall forces velocity to zero.
// - Stall stop holds until status read; event flag shows it.
// - Load value stays readable in fullstep mode, up to 511.
// - Load pulse width 0..255; at least blank time plus one.
// - Stall sensitivity 0..255, higher is more sensitive.
// - In fullstep mode off-time settings 8..15 act as 8.
// - Target readout shows the commanded value, not the slowdown.
// - Store a quarter wave, extend to full period, 10-bit counter addresses.
// - Quarter wave is 256 one-bit entries in eight 32-bit words.
// - Entry bit chooses base slope or slope plus one per advance.
// - Four segments by three boundaries, slopes -1, 0, 1 or 2.
// - Both coil values update each microstep, reload at zero.
// - Start values give wave at zero and the 90-degree shifted coil.
// - One wave table serves both coils and channels.
// - Step advances counter up when direction 0, down when 1, by width.
module wave_sequencer #(
  parameter int VEL_W = wave_seq_pkg::VEL_W,
  parameter int CUR_W = wave_seq_pkg::CUR_W
) (
  // Clock and reset.
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_NRST,
  // Wave table configuration.
  input  wire logic             i_table_we,
  input  wire logic [2:0]       i_table_idx,
  input  wire logic [31:0]      i_wave_increment_bits,
  input  wire logic [31:0]      i_segment_select_word,
  input  wire logic [31:0]      i_start_values_word,
  // Step interface.
  input  wire logic             i_step,
  input  wire logic             i_dir,
  input  wire logic [3:0]       i_step_shift,
  // Fullstep mode configuration.
  input  wire logic [VEL_W-1:0] i_fullstep_mode_min_velocity,
  input  wire logic             i_high_vel_fullstep,
  input  wire logic             i_high_vel_chopper,
  input  wire logic [3:0]       i_chopper_off_time,
  input  wire logic [7:0]       i_load_pulse_width,
  input  wire logic [7:0]       i_adaptive_stall_sensitivity,
  input  wire logic             i_stop_on_stall_enable,
  // Ramp generator and load measurement.
  input  wire logic [VEL_W-1:0] i_ramp_target_velocity,
  input  wire logic             i_motor_overload,
  input  wire logic [8:0]       i_load_measure_raw,
  input  wire logic             i_ramp_status_read,
  // Coil outputs.
  output logic [CUR_W-1:0]      O_COIL_A_CURRENT,
  output logic [CUR_W-1:0]      O_COIL_B_CURRENT,
  output logic [9:0]            O_WAVE_POSITION_COUNTER,
  output logic                  O_STEP_BUSY,
  // Fullstep mode outputs.
  output logic                  O_FULLSTEP_MODE,
  output logic                  O_QUIET_CHOPPER_DISABLE,
  output logic [3:0]            O_CHOPPER_OFF_TIME,
  output logic [7:0]            O_LOAD_PULSE_WIDTH,
  output logic [VEL_W-1:0]      O_MOTOR_VELOCITY,
  output logic [VEL_W-1:0]      O_RAMP_TARGET_VELOCITY,
  output logic [8:0]            O_LOAD_MEASURE_VALUE,
  output logic                  O_STALL_STOP_EVENT_FLAG
);

  // ----------------------------------------------------------------
  // Reset synchroniser.
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Release is made synchronous; assertion still acts at once.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Configuration views.
  // ----------------------------------------------------------------
  wave_seq_pkg::seg_cfg_t   seg;
  wave_seq_pkg::start_cfg_t starts;

  assign seg    = wave_seq_pkg::seg_cfg_t'(i_segment_select_word);
  assign starts = wave_seq_pkg::start_cfg_t'(i_start_values_word);

  // ----------------------------------------------------------------
  // Step walker.
  // ----------------------------------------------------------------
  // A step of 2^shift positions (shift capped at 8) is walked one per cycle so the
  // incremental coil values skip no entry. Steps during a walk are
  // dropped; the ramp side sees O_STEP_BUSY.
  wave_seq_pkg::walk_state_t state;
  wave_seq_pkg::walk_state_t next_state;
  logic [9:0] pos;
  logic [8:0] steps_left;
  logic       walk_dir;
  logic [3:0] shift_cl;
  logic [8:0] width;
  logic       take_step;
  logic       advance;

  assign shift_cl  = (i_step_shift > wave_seq_pkg::MAX_SHIFT) ?
                     wave_seq_pkg::MAX_SHIFT : i_step_shift;
  assign width     = 9'h001 << shift_cl;
  assign take_step = (state == wave_seq_pkg::ST_IDLE) && i_step;
  assign advance   = (state == wave_seq_pkg::ST_WALK);

  // Walker state machine.
  always_comb begin
    next_state = state;
    case (state)
      wave_seq_pkg::ST_IDLE: begin
        if (i_step) next_state = wave_seq_pkg::ST_WALK;
      end
      wave_seq_pkg::ST_WALK: begin
        if (steps_left == 9'h001) next_state = wave_seq_pkg::ST_IDLE;
      end
      default: next_state = wave_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) state <= wave_seq_pkg::ST_IDLE;
    else        state <= next_state;
  end

  // Positions left and direction of the running walk.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      steps_left <= wave_seq_pkg::STEPS_RESET;
      walk_dir   <= 1'b0;
    end else if (take_step) begin
      steps_left <= width;
      walk_dir   <= i_dir;
    end else if (advance) begin
      steps_left <= steps_left - 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Wave position counter.
  // ----------------------------------------------------------------
  logic [9:0] next_pos;
  logic       at_zero;

  // Ten-bit arithmetic wraps 1023 <-> 0 in both directions.
  assign next_pos = walk_dir ? pos - 10'h001 : pos + 10'h001;
  assign at_zero  = (next_pos == 10'h000);

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n)       pos <= wave_seq_pkg::POS_RESET;
    else if (advance) pos <= next_pos;
  end

  // ----------------------------------------------------------------
  // Quarter-wave expansion.
  // ----------------------------------------------------------------
  // Each coil crosses the edge below old and new position.
  // Bit 8 of the edge marks a mirrored quarter,
  // which reads the table backwards.
  // Walking down negates the change.
  logic [1:0][9:0] coil_pos;
  logic [1:0][9:0] edge_pos;
  logic [1:0][7:0] rd_idx;
  logic [1:0][2:0] rd_inc;
  logic [1:0]      sub_inc;

  assign coil_pos[0] = pos;
  assign coil_pos[1] = pos + 10'h100; // Second coil leads by 90 degrees.

  for (genvar c = 0; c < 2; c++) begin : g_edge
    assign edge_pos[c] = walk_dir ? coil_pos[c] - 10'h001 : coil_pos[c];
    assign rd_idx[c]   = edge_pos[c][8] ? ~edge_pos[c][7:0]
                                         : edge_pos[c][7:0];
    assign sub_inc[c]  = edge_pos[c][8] ^ walk_dir;
  end

  // One table, two read ports: both coils see the same wave.
  wave_increment_table #(
    .WORD_W (32),
    .WORDS  (wave_seq_pkg::TABLE_WORDS)
  ) u_table (
    .clk     (I_CORE_CLK),
    .rst_n   (rst_n),
    .wr_en   (i_table_we),
    .wr_idx  (i_table_idx),
    .wr_data (i_wave_increment_bits),
    .seg     (seg),
    .rd_idx  (rd_idx),
    .rd_inc  (rd_inc)
  );

  // ----------------------------------------------------------------
  // Coil magnitudes.
  // ----------------------------------------------------------------
  logic [1:0][8:0] mag;
  logic [1:0][8:0] next_mag;
  logic [1:0][8:0] start_mag;

  assign start_mag[0] = {1'b0, starts.start};
  assign start_mag[1] = {1'b0, starts.shifted};

  // Increment is signed -1..3; sign-extend before adding.
  for (genvar c = 0; c < 2; c++) begin : g_mag
    wire logic [8:0] inc9 = {{6{rd_inc[c][2]}}, rd_inc[c]};
    assign next_mag[c] = at_zero    ? start_mag[c] :
                         sub_inc[c] ? mag[c] - inc9 :
                                      mag[c] + inc9;
  end

  // Both magnitudes move on every walked position.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mag <= {wave_seq_pkg::MAG_RESET, wave_seq_pkg::MAG_RESET};
    end else if (advance) begin
      mag <= next_mag;
    end
  end

  // ----------------------------------------------------------------
  // Signed coil currents.
  // ----------------------------------------------------------------
  // The second half period is the first one negated. Values update in
  // the same cycle as the counter, since the sign follows the stored position.
  logic [1:0][8:0] signed_cur;

  for (genvar c = 0; c < 2; c++) begin : g_sign
    assign signed_cur[c] = coil_pos[c][9] ? 9'h000 - mag[c] : mag[c];
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_COIL_A_CURRENT        <= '0;
      O_COIL_B_CURRENT        <= '0;
      O_WAVE_POSITION_COUNTER <= wave_seq_pkg::POS_RESET;
      O_STEP_BUSY             <= 1'b0;
    end else begin
      O_COIL_A_CURRENT        <= signed_cur[0];
      O_COIL_B_CURRENT        <= signed_cur[1];
      O_WAVE_POSITION_COUNTER <= pos;
      O_STEP_BUSY             <= (next_state == wave_seq_pkg::ST_WALK);
    end
  end

  // ----------------------------------------------------------------
  // Fullstep mode decision.
  // ----------------------------------------------------------------
  // Zero threshold disables the mode; both flags must be set.
  logic mode_enabled;
  logic fs_active;

  assign mode_enabled = (i_fullstep_mode_min_velocity != '0);
  assign fs_active = mode_enabled && i_high_vel_fullstep &&
                     i_high_vel_chopper &&
                     (i_ramp_target_velocity >
                      i_fullstep_mode_min_velocity);

  // ----------------------------------------------------------------
  // Velocity adjust divider.
  // ----------------------------------------------------------------
  localparam int DIV_W = $clog2(wave_seq_pkg::VEL_ADJ_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST =
    DIV_W'(wave_seq_pkg::VEL_ADJ_CYCLES - 1);

  logic [DIV_W-1:0] div_cnt;
  logic             adj_tick;

  assign adj_tick = (div_cnt == DIV_LAST);

  // Free-running divider producing a one-cycle adjust pulse.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n)        div_cnt <= '0;
    else if (adj_tick) div_cnt <= '0;
    else               div_cnt <= div_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // Overload velocity governor.
  // ----------------------------------------------------------------
  logic [VEL_W-1:0] gov_vel;

  fullstep_velocity_ctrl #(
    .VEL_W (VEL_W)
  ) u_gov (
    .clk       (I_CORE_CLK),
    .rst_n     (rst_n),
    .tick      (adj_tick),
    .active    (fs_active),
    .overload  (i_motor_overload),
    .target    (i_ramp_target_velocity),
    .floor_vel (i_fullstep_mode_min_velocity),
    .vel       (gov_vel)
  );

  // ----------------------------------------------------------------
  // Stall stop.
  // ----------------------------------------------------------------
  // Stall: overloaded and load reading below the sensitivity, so a
  // larger setting trips earlier. The stop holds until a status
  // read; a stall in that same cycle wins.
  logic stall_seen;
  logic stall_stop;

  assign stall_seen = fs_active && i_motor_overload &&
                      ({1'b0, i_adaptive_stall_sensitivity} >
                       i_load_measure_raw);

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stall_stop <= 1'b0;
    end else if (stall_seen && i_stop_on_stall_enable) begin
      stall_stop <= 1'b1;
    end else if (i_ramp_status_read) begin
      stall_stop <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Chopper and measurement outputs.
  // ----------------------------------------------------------------
  logic [3:0]       off_time_eff;
  logic [VEL_W-1:0] drive_vel;

  assign off_time_eff = (fs_active &&
                         i_chopper_off_time > wave_seq_pkg::OFF_TIME_CAP) ?
                        wave_seq_pkg::OFF_TIME_CAP :
                        i_chopper_off_time;
  assign drive_vel = stall_stop ? '0 : gov_vel;

  // Registered outputs toward power stage, ramp side and software.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_FULLSTEP_MODE         <= 1'b0;
      O_QUIET_CHOPPER_DISABLE <= 1'b0;
      O_CHOPPER_OFF_TIME      <= '0;
      O_LOAD_PULSE_WIDTH      <= '0;
      O_MOTOR_VELOCITY        <= '0;
      O_RAMP_TARGET_VELOCITY  <= '0;
      O_LOAD_MEASURE_VALUE    <= '0;
      O_STALL_STOP_EVENT_FLAG <= 1'b0;
    end else begin
      O_FULLSTEP_MODE         <= fs_active;
      O_QUIET_CHOPPER_DISABLE <= fs_active;
      O_CHOPPER_OFF_TIME      <= off_time_eff;
      O_LOAD_PULSE_WIDTH      <= i_load_pulse_width;
      O_MOTOR_VELOCITY        <= drive_vel;
      O_RAMP_TARGET_VELOCITY  <= i_ramp_target_velocity;
      O_LOAD_MEASURE_VALUE    <= i_load_measure_raw;
      O_STALL_STOP_EVENT_FLAG <= stall_stop;
    end
  end

endmodule : wave_sequencer

// ===== bench/wave_sequencer_assertions.sv
/* Checker of the sequencer ports.
   Assumes a bind into wave_sequencer. */
module wave_sequencer_assertions (
  // Inputs.
  input wire logic        I_CORE_CLK, I_NRST, i_step, i_dir, i_stop_on_stall_enable,
  input wire logic        i_high_vel_fullstep, i_high_vel_chopper, i_motor_overload,
  input wire logic        i_ramp_status_read,
  input wire logic [3:0]  i_step_shift, i_chopper_off_time,
  input wire logic [7:0]  i_adaptive_stall_sensitivity,
  input wire logic [8:0]  i_load_measure_raw,
  input wire logic [31:0] i_start_values_word,
  input wire logic [22:0] i_fullstep_mode_min_velocity, i_ramp_target_velocity,
  // Outputs.
  input wire logic        O_STEP_BUSY, O_FULLSTEP_MODE, O_QUIET_CHOPPER_DISABLE,
  input wire logic        O_STALL_STOP_EVENT_FLAG,
  input wire logic [3:0]  O_CHOPPER_OFF_TIME,
  input wire logic [8:0]  O_COIL_A_CURRENT, O_COIL_B_CURRENT, O_LOAD_MEASURE_VALUE,
  input wire logic [9:0]  O_WAVE_POSITION_COUNTER,
  input wire logic [22:0] O_MOTOR_VELOCITY, O_RAMP_TARGET_VELOCITY
);
  logic [3:0] up;
  // Outputs lag reset release by three edges; wait four.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) up <= 4'h0;
    else up <= {up[2:0], 1'b1};
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!up[3]);
  // Mode and stall from the inputs.
  wire fs = (i_fullstep_mode_min_velocity != 23'h0) && i_high_vel_fullstep &&
            i_high_vel_chopper && (i_ramp_target_velocity > i_fullstep_mode_min_velocity);
  wire stall = fs && i_motor_overload && i_stop_on_stall_enable &&
               ({1'b0, i_adaptive_stall_sensitivity} > i_load_measure_raw);
  sequence take_one;
    i_step && !O_STEP_BUSY && i_step_shift == 4'h0;
  endsequence
  sequence walk_one;
    O_STEP_BUSY ##1 !O_STEP_BUSY;
  endsequence
  mode_follow_a: assert property (O_FULLSTEP_MODE == $past(fs))
    else $error("mode wrong");
  quiet_off_a: assert property (O_QUIET_CHOPPER_DISABLE == O_FULLSTEP_MODE)
    else $error("quiet wrong");
  off_cap_a: assert property (fs && i_chopper_off_time >= 4'h8 |=> O_CHOPPER_OFF_TIME == 4'h8)
    else $error("off time");
  target_copy_a: assert property (O_RAMP_TARGET_VELOCITY == $past(i_ramp_target_velocity))
    else $error("target");
  load_copy_a: assert property (O_LOAD_MEASURE_VALUE == $past(i_load_measure_raw))
    else $error("load");
  stall_set_a: assert property (stall |-> ##[1:3] O_STALL_STOP_EVENT_FLAG)
    else $error("no stop");
  stop_zero_a: assert property (O_STALL_STOP_EVENT_FLAG && $past(O_STALL_STOP_EVENT_FLAG)
    |-> O_MOTOR_VELOCITY == 23'h0)
    else $error("not stopped");
  stall_hold_a: assert property (O_STALL_STOP_EVENT_FLAG && !i_ramp_status_read &&
    !$past(i_ramp_status_read) |=> O_STALL_STOP_EVENT_FLAG)
    else $error("stop dropped");
  floor_hold_a: assert property (O_FULLSTEP_MODE && $past(O_FULLSTEP_MODE) &&
    !O_STALL_STOP_EVENT_FLAG && $stable(i_fullstep_mode_min_velocity) &&
    $past(O_MOTOR_VELOCITY) >= i_fullstep_mode_min_velocity
    |-> O_MOTOR_VELOCITY >= i_fullstep_mode_min_velocity)
    else $error("under floor");
  step_walk_a: assert property (take_one |=> walk_one ##1 O_WAVE_POSITION_COUNTER ==
    $past(O_WAVE_POSITION_COUNTER, 2) + ($past(i_dir, 3) ? 10'h3FF : 10'h001))
    else $error("step wrong");
  zero_load_a: assert property ($changed(O_WAVE_POSITION_COUNTER) &&
    O_WAVE_POSITION_COUNTER == 10'h000 |->
    O_COIL_A_CURRENT == {1'b0, i_start_values_word[7:0]} &&
    O_COIL_B_CURRENT == {1'b0, i_start_values_word[23:16]})
    else $error("no reload");
endmodule : wave_sequencer_assertions

bind wave_sequencer wave_sequencer_assertions chk_u (.*);

// ===== bench/ramp_cfg_model.sv
/* Ramp generator and software setup model.
   Assumes the bench sets goal, overload and the stall request. */
module ramp_cfg_model #(
  parameter int BLANK = 24
) (
  input  wire logic        clk,
  input  wire logic [22:0] goal,
  input  wire logic        heavy,
  input  wire logic        stall_cmd,
  output logic      [22:0] target = 23'h0,
  output logic             overload = 1'b0,
  output logic      [8:0]  load = 9'h010,
  output logic      [31:0] seg_word,
  output logic      [31:0] start_word,
  output logic      [7:0]  pulse_w,
  output logic      [7:0]  sens
);
  logic [7:0] lf = 8'h5A;
  // Default sine setup; its polarity suits fullstep.
  assign seg_word = 32'hFFFF8056;
  assign start_word = 32'h00F70000;
  // Lowest legal width; sensitivity just above width/16.
  assign pulse_w = 8'(BLANK + 1);
  assign sens = pulse_w / 8'h10 + 8'h01;
  // Load stays above sensitivity unless a stall is asked.
  always @(posedge clk) begin
    lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    target <= goal;
    overload <= heavy;
    load <= stall_cmd ? 9'h000 : 9'h010 + {1'b0, lf};
  end
endmodule : ramp_cfg_model

// ===== bench/wave_sequencer_tb.sv
/* Self-checking bench for the wave sequencer.
   Assumes the partner model drives far-side inputs. */
module wave_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic I_CORE_CLK = 0, I_NRST = 0, i_table_we = 0, i_step = 0, i_dir = 0;
  logic i_high_vel_fullstep = 0, i_high_vel_chopper = 0, i_stop_on_stall_enable = 0;
  logic i_ramp_status_read = 0, i_motor_overload, heavy = 0, stall_cmd = 0, f;
  logic O_STEP_BUSY, O_FULLSTEP_MODE, O_QUIET_CHOPPER_DISABLE, O_STALL_STOP_EVENT_FLAG;
  logic [2:0] i_table_idx = 0;
  logic [3:0] i_step_shift = 0, i_chopper_off_time = 0, O_CHOPPER_OFF_TIME;
  logic [7:0] i_load_pulse_width, i_adaptive_stall_sensitivity, O_LOAD_PULSE_WIDTH;
  logic [8:0] i_load_measure_raw, O_COIL_A_CURRENT, O_COIL_B_CURRENT, O_LOAD_MEASURE_VALUE;
  logic [9:0] O_WAVE_POSITION_COUNTER, pos;
  logic [22:0] i_fullstep_mode_min_velocity = 0, i_ramp_target_velocity, goal = 0, m;
  logic [22:0] O_MOTOR_VELOCITY, O_RAMP_TARGET_VELOCITY;
  logic [31:0] i_wave_increment_bits = 0, i_segment_select_word, i_start_values_word;
  logic [255:0] blank_time_select;
  int seed = 32'hce59;
  int err_count = 0;
  int n_checks = 0;

  always #12.5 I_CORE_CLK = ~I_CORE_CLK;

  wave_sequencer dut_u (.*);
  ramp_cfg_model partner_u (.clk(I_CORE_CLK), .goal(goal), .heavy(heavy),
    .stall_cmd(stall_cmd), .target(i_ramp_target_velocity), .overload(i_motor_overload),
    .load(i_load_measure_raw), .seg_word(i_segment_select_word),
    .start_word(i_start_values_word), .pulse_w(i_load_pulse_width),
    .sens(i_adaptive_stall_sensitivity));

  // Expected quarter-wave value at entry i.
  function automatic int q_at(input int i);
    int q, c;
    wave_seq_pkg::seg_cfg_t g;
    g = i_segment_select_word;
    q = i_start_values_word[7:0];
    for (int k = 0; k < i; k++) begin
      c = k < g.x1 ? g.w0 : k < g.x2 ? g.w1 : k < g.x3 ? g.w2 : g.w3;
      q = q + c - 1 + blank_time_select[k];
    end
    return q;
  endfunction : q_at

  task automatic chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // Inputs change 2 ns after an edge.
  task automatic tick(input int n);
    repeat (n) @(posedge I_CORE_CLK);
    #2;
  endtask : tick

  // One step; a stuck walker ends the run.
  task automatic step(input logic d, input logic [3:0] sh);
    int n;
    i_dir = d;
    i_step_shift = sh;
    i_step = 1;
    tick(1);
    i_step = 0;
    for (n = 0; n < 600 && O_STEP_BUSY !== 1'b0; n++) tick(1);
    if (n == 600) begin
      err_count++;
      wrap_up();
    end
    tick(1);
  endtask : step

  initial begin
    tick(10);
    I_NRST = 1;
    tick(3);
    for (int w = 0; w < 8; w++) begin
      i_table_idx = w[2:0];
      i_wave_increment_bits = $random(seed);
      blank_time_select[w*32 +: 32] = i_wave_increment_bits;
      i_table_we = 1;
      tick(1);
    end
    i_table_we = 0;
    for (int i = 1; i <= 64; i++) begin
      step(0, 4'h0);
      chk("coil_a", 23'(9'(q_at(i))), 23'(O_COIL_A_CURRENT));
    end
    for (int i = 63; i >= 0; i--) begin
      step(1, 4'h0);
      chk("coil_a", 23'(9'(q_at(i))), 23'(O_COIL_A_CURRENT));
    end
    step(1, 4'h0);
    chk("position", 23'h3FF, 23'(O_WAVE_POSITION_COUNTER));
    step(0, 4'h0);
    chk("coil_b", 23'h0F7, 23'(O_COIL_B_CURRENT));
    $display("wave walk done");
    pos = 10'h000;
    for (int s = 0; s < 10; s++) begin
      f = $random(seed);
      pos = f ? pos - (10'h1 << (s > 8 ? 8 : s)) : pos + (10'h1 << (s > 8 ? 8 : s));
      step(f, 4'(s));
      chk("position", 23'(pos), 23'(O_WAVE_POSITION_COUNTER));
    end
    $display("step width done");
    m = (23'($random(seed)) & 23'h3FFFF0) | 23'h10;
    for (int c = 0; c < 6; c++) begin
      i_fullstep_mode_min_velocity = c == 1 ? 23'h0 : c == 5 ? 23'h400000 : m;
      {i_high_vel_fullstep, i_high_vel_chopper} = c == 2 ? 2'b10 : c == 3 ? 2'b01 : 2'b11;
      goal = c == 4 ? m : i_fullstep_mode_min_velocity + 23'h1;
      i_chopper_off_time = 4'hA + 4'(c);
      tick(2);
      f = i_fullstep_mode_min_velocity != 0 && c != 2 && c != 3 && c != 4;
      chk("fullstep", 23'(f), 23'(O_FULLSTEP_MODE));
      chk("quiet_off", 23'(f), 23'(O_QUIET_CHOPPER_DISABLE));
      chk("off_time", f ? 23'h8 : 23'(i_chopper_off_time), 23'(O_CHOPPER_OFF_TIME));
      chk("target", goal, O_RAMP_TARGET_VELOCITY);
    end
    chk("pulse_width", 23'(i_load_pulse_width), 23'(O_LOAD_PULSE_WIDTH));
    $display("mode select done");
    i_fullstep_mode_min_velocity = 23'h0;
    goal = m + 23'h3;
    tick(4);
    i_fullstep_mode_min_velocity = m;
    heavy = 1;
    tick(8 * wave_seq_pkg::VEL_ADJ_CYCLES);
    chk("velocity", m, O_MOTOR_VELOCITY);
    heavy = 0;
    tick(8 * wave_seq_pkg::VEL_ADJ_CYCLES);
    chk("velocity", m + 23'h3, O_MOTOR_VELOCITY);
    chk("target", m + 23'h3, O_RAMP_TARGET_VELOCITY);
    $display("governor done");
    i_stop_on_stall_enable = 1;
    heavy = 1;
    stall_cmd = 1;
    tick(6);
    chk("stall_flag", 23'h1, 23'(O_STALL_STOP_EVENT_FLAG));
    chk("velocity", 23'h0, O_MOTOR_VELOCITY);
    stall_cmd = 0;
    heavy = 0;
    tick(20);
    chk("stall_flag", 23'h1, 23'(O_STALL_STOP_EVENT_FLAG));
    i_ramp_status_read = 1;
    tick(1);
    i_ramp_status_read = 0;
    tick(3);
    chk("stall_flag", 23'h0, 23'(O_STALL_STOP_EVENT_FLAG));
    $display("stall stop done");
    wrap_up();
  end
endmodule : wave_sequencer_tb
